//--- src/fsr_pkg.sv
// package for the serial flash suspend/reset/param-table host controller
`default_nettype none
package fsr_pkg;
  // opcodes
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_NOOP = 8'h00;
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PARAM_RD = 8'h5A;
  localparam logic [7:0] OP_SEC_RD = 8'h2B;
  // suspend flag positions in the security status byte
  localparam int PSUS_BIT = 2;
  localparam int ESUS_BIT = 3;
  // parameter area layout
  localparam logic [31:0] PT_SIGNATURE = 32'h5044_4653;
  localparam logic [7:0] PT_MINOR = 8'h00;
  localparam logic [7:0] PT_MAJOR = 8'h01;
  localparam logic [7:0] PT_NHDR = 8'h01;
  localparam logic [7:0] PT_STD_ID = 8'h00;
  localparam logic [7:0] PT_STD_LEN = 8'h09;
  localparam logic [7:0] PT_STD_PTR = 8'h30;
  localparam logic [7:0] PT_VND_LEN = 8'h04;
  localparam logic [7:0] PT_VND_PTR = 8'h60;
  localparam logic [7:0] PT_UNUSED = 8'hFF;
  localparam int PT_ADDR_BYTES = 3;
  localparam int PT_DUMMY_BYTES = 1;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SUSPEND_US = 20;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam int RESUME_GAP_US = 1000;
  localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;
  localparam int RESET_RECOV_US = 40;
  localparam int RESET_RECOV_CYC = RESET_RECOV_US * CLK_MHZ;
  localparam int SCK_HALF = 4;
  // user orders
  typedef enum logic [2:0] {
    FSR_CMD_NOOP = 3'b000,
    FSR_CMD_SUSPEND = 3'b001,
    FSR_CMD_RESUME = 3'b010,
    FSR_CMD_RESET = 3'b011,
    FSR_CMD_PARAM = 3'b100,
    FSR_CMD_STATUS = 3'b101,
    FSR_CMD_RAW = 3'b110
  } fsr_cmd_t;
  typedef struct packed {
    fsr_cmd_t cmd;
    logic quad;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] nbytes;
  } fsr_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } fsr_rdat_t;
endpackage : fsr_pkg
`default_nettype wire

//--- src/fsr_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module fsr_sync
  import fsr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic CLOCK, // system clock
  input wire logic RESET_N, // async reset, active low
  input wire logic [WIDTH-1:0] d, // asynchronous input
  output logic [WIDTH-1:0] q // synchronised level
);
  logic [WIDTH-1:0] meta;
  // first stage read only by the second
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : fsr_sync
`default_nettype wire

//--- src/fsr_wait.sv
// load-and-count-down wait timer
`default_nettype none
module fsr_wait
  import fsr_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input wire logic CLOCK, // system clock
  input wire logic RESET_N, // async reset, active low
  input wire logic load, // start a wait
  input wire logic [WIDTH-1:0] count, // cycles to wait
  output logic busy // wait in progress
);
  logic [WIDTH-1:0] left;
  logic [WIDTH-1:0] next_left;
  initial begin
    if (WIDTH < 2 || WIDTH > 31) $error("fsr_wait width out of range");
  end
  // load wins over counting
  always_comb begin
    next_left = left;
    if (load) next_left = count;
    else if (left != '0) next_left = left - 1'b1;
  end
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) left <= '0;
    else left <= next_left;
  end
  assign busy = (left != '0);
endmodule : fsr_wait
`default_nettype wire

//--- src/fsr_host.sv
// host controller: suspend/resume, software reset, parameter-table read
// Functional notes
// - Host waits 20us after suspend before trusting the flags.
// - Host waits at least 1ms after resume before next suspend.
// - Commands go as 8 serial clocks or 2 quad clocks.
// - Host must not use reads from the erase-suspended region.
// - Host must not use reads from the program-suspended page region.
// - Resume is chip select low, opcode 30h, chip select high.
// - Host polls busy or waits; no write enable before resume.
// - Resume is ignored while enhanced-read continuation mode is active.
// - Reset works only directly after reset-arm; else disarmed.
// - Host waits reset recovery time before new commands.
// - Param read: 5Ah, 3 address bytes, 1 dummy, then data out.
// - Chip select rises exactly on a byte boundary.
`default_nettype none
module fsr_host
  import fsr_pkg::*;
#(
  parameter int SUSPEND_WAIT = SUSPEND_CYC,
  parameter int RESUME_WAIT = RESUME_GAP_CYC,
  parameter int RESET_WAIT = RESET_RECOV_CYC
) (
  input wire logic CLOCK, // system clock 100 MHz
  input wire logic RESET_N, // async reset, active low
  input wire fsr_req_t REQ, // user order
  input wire logic REQ_VALID, // order strobe
  output logic REQ_READY, // idle, order may be given
  output fsr_rdat_t RDATA, // byte read back
  output logic DONE, // order finished pulse
  output logic REFUSED, // order refused pulse
  output logic SUSP_PROG, // last seen program-suspend flag
  output logic SUSP_ERASE, // last seen erase-suspend flag
  output logic SIG_OK, // parameter header check passed
  output logic FLASH_CS_N, // chip select, active low
  output logic FLASH_SCK, // serial clock to device
  output logic [3:0] FLASH_DO, // data lines out
  output logic [3:0] FLASH_OE, // data line drive enables
  input wire logic [3:0] FLASH_DI // data lines in
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_GAP = 3'b010,
    ST_WAIT = 3'b011
  } fsr_state_t;

  initial begin
    // the wait timers hold 24 bits
    if (SUSPEND_WAIT < 1 || RESUME_WAIT < 1 || RESET_WAIT < 1 ||
        SUSPEND_WAIT > 24'hFF_FFFF || RESUME_WAIT > 24'hFF_FFFF ||
        RESET_WAIT > 24'hFF_FFFF)
      $error("fsr_host wait counts out of range");
  end

  logic [3:0] di_s;
  fsr_sync #(.WIDTH(4)) u_sync (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .d(FLASH_DI), .q(di_s));

  fsr_state_t state, next_state;
  logic [7:0] sh_out, next_sh_out;
  logic [7:0] sh_in, next_sh_in;
  logic [3:0] bitcnt, next_bitcnt; // edges left in current byte
  logic [7:0] bytes, next_bytes; // address and dummy bytes left to send
  logic [7:0] rbytes, next_rbytes; // read-phase bytes
  logic [2:0] half, next_half;
  logic quad, next_quad;
  logic reading, next_reading;
  logic [23:0] addr, next_addr;
  fsr_cmd_t cur, next_cur;
  logic armed, next_armed;
  logic second, next_second;
  logic [4:0] ridx, next_ridx;
  logic sig_bad, next_sig_bad;
  logic cs_n, next_cs_n, sck, next_sck;
  logic [3:0] dout, next_dout, oe, next_oe;
  fsr_rdat_t rd, next_rd;
  logic done, next_done, refd, next_refd;
  logic sp, next_sp, se, next_se, sok, next_sok;
  logic resume_block; // resume->suspend gap running
  logic ready, next_ready; // registered idle flag for the ready port
  logic wt_busy, wt_load, gap_load;
  logic [23:0] wt_count;

  // general wait: suspend latency and reset recovery
  fsr_wait #(.WIDTH(24)) u_wait (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .load(wt_load),
    .count(wt_count), .busy(wt_busy));
  // separate timer so a 1ms gap overlaps other orders
  fsr_wait #(.WIDTH(24)) u_gap (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .load(gap_load),
    .count(24'(RESUME_WAIT)), .busy(resume_block));

  // expected param header byte at index
  function automatic logic [7:0] pt_byte(input logic [4:0] i);
    logic [7:0] b;
    b = PT_UNUSED;
    unique case (i)
      5'h00: b = PT_SIGNATURE[7:0];
      5'h01: b = PT_SIGNATURE[15:8];
      5'h02: b = PT_SIGNATURE[23:16];
      5'h03: b = PT_SIGNATURE[31:24];
      5'h04: b = PT_MINOR;
      5'h05: b = PT_MAJOR;
      5'h06: b = PT_NHDR;
      5'h08: b = PT_STD_ID;
      5'h09: b = PT_MINOR;
      5'h0A: b = PT_MAJOR;
      5'h0B: b = PT_STD_LEN;
      5'h0C: b = PT_STD_PTR;
      5'h0D, 5'h0E, 5'h15, 5'h16: b = 8'h00;
      5'h11: b = PT_MINOR;
      5'h12: b = PT_MAJOR;
      5'h13: b = PT_VND_LEN;
      5'h14: b = PT_VND_PTR;
      default: b = PT_UNUSED;
    endcase
    return b;
  endfunction : pt_byte

  // frame engine: command, address, dummy, data phases
  always_comb begin
    logic step;
    step = 1'b0;
    next_state = state;
    next_sh_out = sh_out;
    next_sh_in = sh_in;
    next_bitcnt = bitcnt;
    next_bytes = bytes;
    next_rbytes = rbytes;
    next_half = half;
    next_quad = quad;
    next_reading = reading;
    next_addr = addr;
    next_cur = cur;
    next_armed = armed;
    next_second = second;
    next_ridx = ridx;
    next_sig_bad = sig_bad;
    next_cs_n = cs_n;
    next_sck = sck;
    next_dout = dout;
    next_oe = oe;
    next_rd = '0;
    next_done = 1'b0;
    next_refd = 1'b0;
    next_sp = sp;
    next_se = se;
    next_sok = sok;
    wt_load = 1'b0;
    wt_count = '0;
    gap_load = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (REQ_VALID) begin
          next_cur = REQ.cmd;
          next_quad = REQ.quad;
          next_addr = REQ.addr;
          next_second = 1'b0;
          next_reading = 1'b0;
          next_ridx = '0;
          next_bytes = 8'd0;
          next_rbytes = 8'd0;
          next_sh_out = REQ.opcode;
          unique case (REQ.cmd)
            FSR_CMD_SUSPEND: next_sh_out = OP_SUSPEND;
            FSR_CMD_RESUME: next_sh_out = OP_RESUME;
            FSR_CMD_NOOP: next_sh_out = OP_NOOP;
            FSR_CMD_RESET: next_sh_out = OP_RST_ARM;
            FSR_CMD_PARAM: begin
              next_sh_out = OP_PARAM_RD;
              next_bytes = 8'(PT_ADDR_BYTES + PT_DUMMY_BYTES);
              next_rbytes = REQ.nbytes;
              next_sig_bad = 1'b0;
              next_ridx = REQ.addr[4:0]; // compare from the start address
            end
            FSR_CMD_STATUS: begin
              next_sh_out = OP_SEC_RD;
              next_rbytes = 8'd1;
            end
            // raw bytes pass on unjudged; caller skips the suspended region
            default: next_rbytes = REQ.nbytes; // raw read
          endcase
          if (REQ.cmd == FSR_CMD_SUSPEND && resume_block) begin
            next_refd = 1'b1;
          end else begin
            next_state = ST_SHIFT;
            next_cs_n = 1'b0;
            next_half = '0;
            next_bitcnt = REQ.quad ? 4'd2 : 4'd8;
            next_oe = REQ.quad ? 4'hF : 4'h1;
            next_dout = REQ.quad ? next_sh_out[7:4] : {3'b000, next_sh_out[7]};
          end
        end
      end
      ST_SHIFT: begin
        next_half = half + 3'd1;
        if (half == 3'(SCK_HALF - 1)) begin
          next_half = '0;
          next_sck = ~sck;
          step = sck; // falling edge: shift out
          if (!sck) begin
            // rising edge: sample
            next_sh_in = quad ? {sh_in[3:0], di_s} : {sh_in[6:0], di_s[1]};
          end
        end
        if (step) begin
          next_bitcnt = bitcnt - 4'd1;
          next_sh_out = quad ? {sh_out[3:0], 4'h0} : {sh_out[6:0], 1'b0};
          if (bitcnt == 4'd1) begin
            // byte boundary: only place cs may rise
            if (bytes != 8'd0) begin
              next_bytes = bytes - 8'd1;
              next_sh_out = (bytes > 8'(PT_DUMMY_BYTES)) ?
                addr[23:16] : 8'h00;
              next_addr = {addr[15:0], 8'h00};
              next_bitcnt = quad ? 4'd2 : 4'd8;
            end else if (reading) begin
              next_rd.data = next_sh_in;
              next_rd.valid = 1'b1;
              if (cur == FSR_CMD_STATUS) begin
                next_sp = next_sh_in[PSUS_BIT];
                next_se = next_sh_in[ESUS_BIT];
              end
              if (cur == FSR_CMD_PARAM) begin
                // vendor code byte belongs to the maker; not compared
                if (ridx != 5'h10 && next_sh_in != pt_byte(ridx))
                  next_sig_bad = 1'b1;
                next_ridx = ridx + 5'd1;
              end
              next_rbytes = rbytes - 8'd1;
              next_bitcnt = quad ? 4'd2 : 4'd8;
            end else if (rbytes != 8'd0) begin
              next_reading = 1'b1;
              next_oe = 4'h0;
              next_bitcnt = quad ? 4'd2 : 4'd8;
            end
            if (next_bitcnt == 4'd1 || (bytes == 8'd0 &&
                (reading ? rbytes == 8'd1 : rbytes == 8'd0))) begin
              next_state = ST_GAP;
              next_cs_n = 1'b1;
              next_oe = 4'h0;
            end
          end
          next_dout = quad ? next_sh_out[7:4] : {3'b000, next_sh_out[7]};
        end
      end
      ST_GAP: begin
        // frame ended; decide on second frame or wait
        if (cur == FSR_CMD_RESET && !second) begin
          next_armed = 1'b1;
          next_second = 1'b1; // reset follows arm directly
          next_sh_out = OP_RESET;
          next_state = ST_SHIFT;
          next_cs_n = 1'b0;
          next_bitcnt = quad ? 4'd2 : 4'd8;
          next_oe = quad ? 4'hF : 4'h1;
          next_dout = quad ? OP_RESET[7:4] : {3'b000, OP_RESET[7]};
        end else begin
          next_armed = 1'b0;
          if (cur == FSR_CMD_RESET) begin
            wt_load = 1'b1;
            wt_count = 24'(RESET_WAIT);
            next_sp = 1'b0;
            next_se = 1'b0;
            next_state = ST_WAIT;
          end else if (cur == FSR_CMD_SUSPEND) begin
            wt_load = 1'b1;
            wt_count = 24'(SUSPEND_WAIT);
            next_state = ST_WAIT;
          end else begin
            if (cur == FSR_CMD_RESUME) begin
              gap_load = 1'b1;
              next_sp = 1'b0;
              next_se = 1'b0;
            end
            if (cur == FSR_CMD_PARAM) next_sok = ~sig_bad;
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        if (!wt_busy) begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      ready <= 1'b1;
      sh_out <= '0;
      sh_in <= '0;
      bitcnt <= '0;
      bytes <= '0;
      rbytes <= '0;
      half <= '0;
      quad <= 1'b0;
      reading <= 1'b0;
      addr <= '0;
      cur <= FSR_CMD_NOOP;
      armed <= 1'b0;
      second <= 1'b0;
      ridx <= '0;
      sig_bad <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      dout <= '0;
      oe <= '0;
      rd <= '0;
      done <= 1'b0;
      refd <= 1'b0;
      sp <= 1'b0;
      se <= 1'b0;
      sok <= 1'b0;
    end else begin
      state <= next_state;
      ready <= next_ready;
      sh_out <= next_sh_out;
      sh_in <= next_sh_in;
      bitcnt <= next_bitcnt;
      bytes <= next_bytes;
      rbytes <= next_rbytes;
      half <= next_half;
      quad <= next_quad;
      reading <= next_reading;
      addr <= next_addr;
      cur <= next_cur;
      armed <= next_armed;
      second <= next_second;
      ridx <= next_ridx;
      sig_bad <= next_sig_bad;
      cs_n <= next_cs_n;
      sck <= next_sck;
      dout <= next_dout;
      oe <= next_oe;
      rd <= next_rd;
      done <= next_done;
      refd <= next_refd;
      sp <= next_sp;
      se <= next_se;
      sok <= next_sok;
    end
  end

  // ready from its own flop so the port carries no decode
  assign next_ready = (next_state == ST_IDLE);
  assign REQ_READY = ready;
  assign RDATA = rd;
  assign DONE = done;
  assign REFUSED = refd;
  assign SUSP_PROG = sp;
  assign SUSP_ERASE = se;
  assign SIG_OK = sok;
  assign FLASH_CS_N = cs_n;
  assign FLASH_SCK = sck;
  assign FLASH_DO = dout;
  assign FLASH_OE = oe;

  // checks
  chk_cs_idle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    state == ST_IDLE |-> cs_n) else $error("cs low in idle");
  chk_gap_refuse: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == ST_IDLE && REQ_VALID && REQ.cmd == FSR_CMD_SUSPEND
     && resume_block) |=> refd && state == ST_IDLE)
    else $error("suspend in resume gap not refused");
  chk_sus_wait: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == ST_GAP && cur == FSR_CMD_SUSPEND) |=> state == ST_WAIT)
    else $error("suspend wait skipped");
  chk_reset_pair: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == ST_GAP && cur == FSR_CMD_RESET && !second)
    |=> armed && !cs_n) else $error("reset not after arm");
  chk_disarm: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(done) |-> !armed) else $error("arm left set");
  chk_resume_clr: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == ST_GAP && cur == FSR_CMD_RESUME) |=> !sp && !se
    && resume_block) else $error("resume flags");
  chk_rst_recov: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == ST_GAP && cur == FSR_CMD_RESET && second) |=>
    state == ST_WAIT [*2]) else $error("reset recovery short");
  chk_cs_boundary: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(cs_n) |-> state == ST_GAP) else $error("cs off boundary");
  chk_oe_cs: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    cs_n |-> oe == 4'h0) else $error("driving while deselected");
  cov_suspend: cover property (@(posedge CLOCK)
    state == ST_GAP && cur == FSR_CMD_SUSPEND);
  cov_resume: cover property (@(posedge CLOCK)
    state == ST_GAP && cur == FSR_CMD_RESUME);
  cov_reset: cover property (@(posedge CLOCK)
    state == ST_WAIT && cur == FSR_CMD_RESET);
  cov_param: cover property (@(posedge CLOCK) $rose(sok));
endmodule : fsr_host
`default_nettype wire

//--- tb/fsr_flash_model.sv
// behavioural serial flash answering the suspend/reset/param-table host
`default_nettype none
module fsr_flash_model
  import fsr_pkg::*;
#(
  parameter logic [7:0] VENDOR_ID = 8'h5E, // arbitrary vendor code
  parameter int SUSP_NS = 150 // suspend settling, inside the host wait
) (
  input wire logic cs_n, // chip select, active low
  input wire logic sck, // serial clock from host
  input wire logic [3:0] dio_in, // data lines from host
  input wire logic quad, // two-clock nibble framing
  input wire logic erase_op, // 1 erase running, 0 program running
  output logic [3:0] dio_out // data lines to host
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh, op, obyte;
  logic [23:0] addr;
  logic armed, psus, esus, write_enable_latch;
  int nbit, ix;
  logic [7:0] tbl [24];
  // header area and volatile state at power-up
  initial begin
    tbl = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
      8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
      VENDOR_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};
    {armed, psus, esus, write_enable_latch} = 4'h0;
    nbit = 0;
    op = 8'h00;
    addr = 24'h00_0000;
    dio_out = 4'h0;
  end
  // bits taken on the rising edge; upper lines unused in serial
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = quad ? {sh[3:0], dio_in} : {sh[6:0], dio_in[0]};
      nbit = nbit + (quad ? 4 : 1);
      if (nbit == 8) op = sh;
      if (op == OP_PARAM_RD && nbit % 8 == 0 && nbit > 8 && nbit <= 32)
        addr = {addr[15:0], sh};
    end
  end
  // shift out on the falling edge; released lines toggle, never hold
  always @(negedge sck) begin
    if (!cs_n && op == OP_PARAM_RD && nbit >= 40) begin
      ix = int'(addr) + (nbit - 40) / 8;
      obyte = (ix < 24) ? tbl[ix] : 8'hFF;
      dio_out = {4{obyte[7 - (nbit - 40) % 8]}};
    end else if (!cs_n && op == OP_SEC_RD && nbit >= 8) begin
      obyte = {4'h0, esus, psus, 2'b00};
      dio_out = {4{obyte[7 - nbit % 8]}};
    end else
      dio_out = ~dio_out;
  end
  // new frame
  always @(negedge cs_n) begin
    nbit = 0;
    op = 8'h00;
  end
  // single-byte commands act only when select rises on a whole byte
  always @(posedge cs_n) begin
    dio_out = ~dio_out;
    if (nbit == 8) begin
      if ((psus || esus) && !(op inside {OP_RESUME, OP_RST_ARM, OP_RESET,
          OP_NOOP, OP_READ, OP_SEC_RD, OP_PARAM_RD, OP_SUSPEND, OP_WR_EN}))
        op = 8'hFF;
      case (op)
        OP_SUSPEND: begin
          write_enable_latch = 1'b0;
          if (erase_op) esus <= #SUSP_NS 1'b1;
          else psus <= #SUSP_NS 1'b1;
        end
        OP_RESUME: {psus, esus} = 2'b00;
        OP_WR_EN: write_enable_latch = 1'b1;
        OP_RESET: if (armed) {psus, esus, write_enable_latch} = 3'b000;
        default: ;
      endcase
    end
    armed = (nbit == 8 && op == OP_RST_ARM);
  end
endmodule : fsr_flash_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the flash suspend/reset/param-table host
`default_nettype none
module tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VENDOR = 8'h5E; // arbitrary vendor code
  localparam logic [23:0] A0 = 24'h00_0000;
  typedef struct {
    fsr_req_t r;
    logic er;
    int gap;
    logic rf;
    logic ps;
    logic es;
  } fsr_row_t;
  logic CLOCK = 1'b0;
  logic RESET_N = 1'b0;
  fsr_req_t REQ = '0;
  logic REQ_VALID = 1'b0;
  logic erase_op = 1'b0;
  logic REQ_READY, DONE, REFUSED, SUSP_PROG, SUSP_ERASE, SIG_OK;
  logic FLASH_CS_N, FLASH_SCK, got_ref;
  fsr_rdat_t RDATA;
  logic [3:0] FLASH_DO, FLASH_OE, FLASH_DI;
  int err_count = 0;
  int check_count = 0;
  int nrise = 0;
  logic [7:0] rx [$];
  logic [7:0] exp_tbl [24];
  fsr_row_t rows [9];

  always #5 CLOCK = ~CLOCK;

  // short waits keep the run brief
  fsr_host #(.SUSPEND_WAIT(20), .RESUME_WAIT(50), .RESET_WAIT(30)) dut_u (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .REQ(REQ), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .RDATA(RDATA), .DONE(DONE), .REFUSED(REFUSED),
    .SUSP_PROG(SUSP_PROG), .SUSP_ERASE(SUSP_ERASE), .SIG_OK(SIG_OK),
    .FLASH_CS_N(FLASH_CS_N), .FLASH_SCK(FLASH_SCK), .FLASH_DO(FLASH_DO),
    .FLASH_OE(FLASH_OE), .FLASH_DI(FLASH_DI));
  // undriven lines reach the device as zero
  fsr_flash_model #(.VENDOR_ID(VENDOR)) flash_u (
    .cs_n(FLASH_CS_N), .sck(FLASH_SCK), .dio_in(FLASH_DO & FLASH_OE),
    .quad(REQ.quad), .erase_op(erase_op), .dio_out(FLASH_DI));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  function automatic fsr_req_t rq(input fsr_cmd_t c, input logic [7:0] o,
      input logic [23:0] a, input logic [7:0] n);
    rq = '{c, 1'b0, o, a, n};
  endfunction : rq

  function automatic fsr_row_t mk(input fsr_cmd_t c, input int q, er, g,
      rf, ps, es);
    mk = '{rq(c, 8'h00, A0, 8'h01), 1'(er), g, 1'(rf), 1'(ps), 1'(es)};
    mk.r.quad = 1'(q);
  endfunction : mk

  // one order, held until taken, then wait for its end
  task automatic do_op(input fsr_req_t r);
    int n;
    rx.delete();
    REQ = r;
    REQ_VALID = 1'b1;
    while (REQ_READY !== 1'b1) @(negedge CLOCK);
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    for (n = 0; n < 8000; n++) begin
      if (DONE === 1'b1 || REFUSED === 1'b1) break;
      @(negedge CLOCK);
    end
    got_ref = REFUSED;
    if (n == 8000) check(0, 1);
  endtask : do_op

  task automatic pread(input logic [23:0] a, input logic [7:0] n);
    do_op(rq(FSR_CMD_PARAM, 8'h00, a, n));
    check(rx.size(), n);
    foreach (rx[j])
      check(rx[j], (a + j < 24) ? exp_tbl[a + j] : 8'hFF);
  endtask : pread

  // read bytes and clock edges per frame, seen off the sampling edge
  always @(negedge CLOCK) if (RDATA.valid === 1'b1) rx.push_back(RDATA.data);
  always @(posedge FLASH_SCK) nrise++;
  always @(negedge FLASH_CS_N) nrise = 0;
  always @(posedge FLASH_CS_N)
    if (RESET_N === 1'b1)
      check(nrise % (REQ.quad ? 2 : 8), 0);

  // whole run needs well under 20000 cycles
  initial begin
    #200_000;
    err_count++;
    $display("watchdog expired at t=%0t", $time);
    conclude();
  end

  initial begin
    exp_tbl = '{PT_SIGNATURE[7:0], PT_SIGNATURE[15:8], PT_SIGNATURE[23:16],
      PT_SIGNATURE[31:24], PT_MINOR, PT_MAJOR, PT_NHDR, PT_UNUSED, PT_STD_ID,
      8'h00, 8'h01, PT_STD_LEN, PT_STD_PTR, 8'h00, 8'h00, PT_UNUSED, VENDOR,
      8'h00, 8'h01, PT_VND_LEN, PT_VND_PTR, 8'h00, 8'h00, PT_UNUSED};
    // cmd, quad, erase, gap, refused, prog flag, erase flag
    rows = '{mk(FSR_CMD_STATUS, 0, 0, 0, 0, 0, 0),
      mk(FSR_CMD_SUSPEND, 0, 1, 0, 0, 0, 0), mk(FSR_CMD_STATUS, 0, 1, 0, 0, 0, 1),
      mk(FSR_CMD_RESUME, 0, 1, 0, 0, 0, 0), mk(FSR_CMD_SUSPEND, 0, 1, 0, 1, 0, 0),
      mk(FSR_CMD_SUSPEND, 1, 0, 60, 0, 0, 0), mk(FSR_CMD_STATUS, 0, 0, 0, 0, 1, 0),
      mk(FSR_CMD_RESET, 1, 0, 0, 0, 0, 0), mk(FSR_CMD_STATUS, 0, 0, 0, 0, 0, 0)};
    repeat (16) @(negedge CLOCK);
    RESET_N = 1'b1;
    for (int i = 0; i < 9; i++) begin
      repeat (rows[i].gap) @(negedge CLOCK);
      erase_op = rows[i].er;
      do_op(rows[i].r);
      check(got_ref, rows[i].rf);
      check(SUSP_PROG, rows[i].ps);
      check(SUSP_ERASE, rows[i].es);
      $display("row %0d done", i);
    end
    // whole header, then the second header running past the area end
    pread(A0, 8'd24);
    check(SIG_OK, 1);
    pread(24'h00_0010, 8'd10);
    check(SIG_OK, 1);
    $display("param read test done");
    // a no-operation between arm and reset drops the arm
    erase_op = 1'b0;
    do_op(rq(FSR_CMD_SUSPEND, 8'h00, A0, 8'h00));
    do_op(rq(FSR_CMD_RAW, OP_RST_ARM, A0, 8'h00));
    do_op(rq(FSR_CMD_NOOP, 8'h00, A0, 8'h00));
    do_op(rq(FSR_CMD_RAW, OP_RESET, A0, 8'h00));
    do_op(rq(FSR_CMD_STATUS, 8'h00, A0, 8'h01));
    check(SUSP_PROG, 1);
    $display("disarm test done");
    // reset between orders brings every output back to idle
    RESET_N = 1'b0;
    @(negedge CLOCK);
    check({REQ_READY, FLASH_CS_N, DONE, SUSP_PROG, SIG_OK, FLASH_SCK,
      FLASH_OE}, 32'h0000_0300);
    RESET_N = 1'b1;
    @(negedge CLOCK);
    // arm then reset back to back aborts the suspended program
    do_op(rq(FSR_CMD_RAW, OP_RST_ARM, A0, 8'h00));
    do_op(rq(FSR_CMD_RAW, OP_RESET, A0, 8'h00));
    repeat (30) @(negedge CLOCK);
    do_op(rq(FSR_CMD_STATUS, 8'h00, A0, 8'h01));
    check(SUSP_PROG, 0);
    $display("reset test done");
    conclude();
  end
endmodule : tb
`default_nettype wire
